// ### sfic_cmd.v
/*
 Identification and software reset command interpreter of a serial
 flash: identification read, unique serial read, no-op, reset arm and
 reset execute. Assumes SPI mode 0/3 pins sampled as synchronous
 inputs at core_clk, with core_clk well above the serial clock rate.
*/
`timescale 1ns/1ps
`default_nettype none
`include "sfic_defs.vh"
module sfic_cmd #(
    parameter [7:0]   MFR_ID    = `SFIC_MFR_DEFAULT,
    parameter [7:0]   MEM_TYPE  = `SFIC_TYPE_DEFAULT,
    parameter [7:0]   MEM_DENS  = `SFIC_DENS_DEFAULT,
    parameter [127:0] SERIAL_NO = 128'h0123456789ABCDEF0F1E2D3C4B5A6978
) (
    input  wire core_clk,
    input  wire arst_n,
    input  wire spi_cs_n,
    input  wire spi_sclk,
    input  wire spi_si,
    output reg  spi_so,
    output reg  spi_so_oe,
    input  wire busy,
    output reg  soft_reset,
    output reg  abort_cycle,
    output wire reset_armed
);
    // ------------------------------------------------------------
    // States
    // ------------------------------------------------------------
    localparam [1:0] ST_CMD   = 2'h0;
    localparam [1:0] ST_DUMMY = 2'h1;
    localparam [1:0] ST_OUT   = 2'h2;
    localparam [1:0] ST_IGN   = 2'h3;

    reg       sclk_q;
    reg       cs_q;
    reg [1:0] state;
    reg [2:0] dummy_cnt;
    reg [7:0] bits_left;
    reg [127:0] out_shift;
    reg       armed;
    wire      rise = spi_sclk & ~sclk_q;
    wire      fall = ~spi_sclk & sclk_q;
    wire      cs_active = ~spi_cs_n;
    wire      cs_end = spi_cs_n & ~cs_q;
    wire [7:0] rx_byte;
    wire       rx_valid;
    wire       opcode_strobe;
    reg        op_read_id;
    reg        op_serial;
    reg        op_arm;
    reg        op_exec;
    reg        op_no_op;

    assign reset_armed = armed;
    // A complete byte while waiting in a frame is an opcode
    assign opcode_strobe = cs_active & rx_valid & (state == ST_CMD);

    sfic_rx_byte u_rx (
        .core_clk (core_clk),
        .arst_n   (arst_n),
        .cs_active(cs_active),
        .rise     (rise),
        .din      (spi_si),
        .rx_byte  (rx_byte),
        .rx_valid (rx_valid)
    );

    // ------------------------------------------------------------
    // Edge history of the serial pins
    // ------------------------------------------------------------
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_q <= 1'b0;
            cs_q   <= 1'b1;
        end else begin
            sclk_q <= spi_sclk;
            cs_q   <= spi_cs_n;
        end
    end

    // ------------------------------------------------------------
    // Opcode classification
    // ------------------------------------------------------------
    // One flag per command keeps the sequencer free of byte compares
    always @* begin
        op_read_id = 1'b0;
        op_serial  = 1'b0;
        op_arm     = 1'b0;
        op_exec    = 1'b0;
        op_no_op   = 1'b0;
        if (rx_byte == `SFIC_OP_READ_ID) begin
            op_read_id = 1'b1;
        end else if (rx_byte == `SFIC_OP_SERIAL_READ) begin
            op_serial = 1'b1;
        end else if (rx_byte == `SFIC_OP_RESET_ARM) begin
            op_arm = 1'b1;
        end else if (rx_byte == `SFIC_OP_RESET_EXEC) begin
            op_exec = 1'b1;
        end else if (rx_byte == `SFIC_OP_NO_OP) begin
            op_no_op = 1'b1;
        end
    end

    // ------------------------------------------------------------
    // Reset arm flag
    // ------------------------------------------------------------
    // Only a completed opcode moves the flag; a frame cut before its
    // first byte leaves an earlier arm pending
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            armed <= 1'b0;
        end else if (opcode_strobe) begin
            // Arming survives only into the very next opcode
            armed <= op_arm;
        end
    end

    // ------------------------------------------------------------
    // Software reset pulses
    // ------------------------------------------------------------
    // One-cycle strobes; the rest of the device clears its volatile
    // state and stops a running program or erase on them
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            soft_reset  <= 1'b0;
            abort_cycle <= 1'b0;
        end else begin
            soft_reset  <= opcode_strobe & op_exec & armed;
            abort_cycle <= opcode_strobe & op_exec & armed & busy;
        end
    end

    // ------------------------------------------------------------
    // Command decode and output sequencing
    // ------------------------------------------------------------
    // The serial value is a parameter only, so nothing can write it.
    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            state     <= ST_CMD;
            dummy_cnt <= 3'h0;
            bits_left <= 8'h00;
            out_shift <= 128'h0;
            spi_so    <= 1'b0;
            spi_so_oe <= 1'b0;
        end else begin
            if (!cs_active) begin
                state     <= ST_CMD;
                spi_so_oe <= 1'b0;
                bits_left <= 8'h00;
                // Park the data line low after an idle frame
                if (cs_end && state == ST_CMD) begin
                    spi_so <= 1'b0;
                end
            end else begin
                case (state)
                ST_CMD: begin
                    if (rx_valid) begin
                        if (op_exec && armed) begin
                            // Rest of the frame is ignored after reset
                            state <= ST_IGN;
                        end else if (op_read_id && !busy) begin
                            out_shift <= {MFR_ID, MEM_TYPE, MEM_DENS,
                                          104'h0};
                            bits_left <= `SFIC_ID_BITS;
                            state     <= ST_OUT;
                        end else if (op_serial) begin
                            dummy_cnt <= 3'h0;
                            state     <= ST_DUMMY;
                        end else if (op_no_op) begin
                            // No-op touches nothing but the arm flag
                            state <= ST_IGN;
                        end else begin
                            // Reset arm, unarmed execute, unknown opcodes and refused reads
                            state <= ST_IGN;
                        end
                    end
                end
                ST_DUMMY: begin
                    if (rx_valid) begin
                        if (dummy_cnt == `SFIC_DUMMY_BYTES - 3'h1) begin
                            out_shift <= SERIAL_NO;
                            bits_left <= `SFIC_SERIAL_BITS;
                            state     <= ST_OUT;
                        end else begin
                            dummy_cnt <= dummy_cnt + 3'h1;
                        end
                    end
                end
                ST_OUT: begin
                    // First bit is driven on the fall after the last
                    // opcode or dummy bit is sampled
                    if (fall) begin
                        if (bits_left != 8'h00) begin
                            spi_so    <= out_shift[127];
                            spi_so_oe <= 1'b1;
                            out_shift <= {out_shift[126:0], 1'b0};
                            bits_left <= bits_left - 8'h01;
                        end else begin
                            spi_so_oe <= 1'b0;
                            state     <= ST_IGN;
                        end
                    end
                end
                default: begin
                    spi_so_oe <= 1'b0;
                end
                endcase
            end
        end
    end
endmodule // sfic_cmd
`default_nettype wire

// ### sfic_cmd_assertions.sv
/* Port timing checker for sfic_cmd.
   Assumes one clock domain and a bind onto sfic_cmd. */
`timescale 1ns/1ps
`default_nettype none
module sfic_cmd_assertions (
    input wire logic core_clk,
    input wire logic arst_n,
    input wire logic spi_cs_n,
    input wire logic spi_sclk,
    input wire logic spi_so,
    input wire logic spi_so_oe,
    input wire logic busy,
    input wire logic soft_reset,
    input wire logic abort_cycle,
    input wire logic reset_armed
);
    // ------------------------------------------------------------
    // Relations between the ports
    // ------------------------------------------------------------
    // Serial clock rises seen in the current frame, saturating
    logic       sclk_d;
    logic [7:0] n_rise;
    always_ff @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            sclk_d <= 1'b0;
            n_rise <= 8'h00;
        end else begin
            sclk_d <= spi_sclk;
            if (spi_cs_n) n_rise <= 8'h00;
            else if (spi_sclk && !sclk_d && n_rise != 8'hFF)
                n_rise <= n_rise + 8'h01;
        end
    end
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!arst_n);
    property p_rst_pulse; soft_reset |=> !soft_reset; endproperty
    a_rst_pulse: assert property (p_rst_pulse)
        else $error("reset pulse too long");
    property p_abt; soft_reset |-> abort_cycle == $past(busy); endproperty
    a_abt: assert property (p_abt)
        else $error("abort does not follow busy");
    property p_abt_rst; abort_cycle |-> soft_reset; endproperty
    a_abt_rst: assert property (p_abt_rst)
        else $error("abort without reset");
    property p_rst_arm;
        soft_reset |-> $past(reset_armed) || $past(reset_armed, 2);
    endproperty
    a_rst_arm: assert property (p_rst_arm)
        else $error("reset without arm");
    property p_arm_clr; soft_reset |=> ##[0:1] !reset_armed; endproperty
    a_arm_clr: assert property (p_arm_clr)
        else $error("arm kept after reset");
    property p_arm_frame; $rose(reset_armed) |-> !spi_cs_n; endproperty
    a_arm_frame: assert property (p_arm_frame)
        else $error("arm outside a frame");
    property p_oe_cs; spi_cs_n [*2] |=> !spi_so_oe; endproperty
    a_oe_cs: assert property (p_oe_cs)
        else $error("output driven while deselected");
    property p_so_fall;
        spi_so_oe && $past(spi_so_oe) && spi_so != $past(spi_so) |-> !spi_sclk;
    endproperty
    a_so_fall: assert property (p_so_fall)
        else $error("output changed on high clock");
    // While busy only the serial read may drive, after more than eight rises
    property p_busy_id;
        $rose(spi_so_oe) && busy |-> n_rise > 8'h08;
    endproperty
    a_busy_id: assert property (p_busy_id)
        else $error("output started while busy");
endmodule // sfic_cmd_assertions
bind sfic_cmd sfic_cmd_assertions i_chk (.core_clk(core_clk),
    .arst_n(arst_n), .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk),
    .spi_so(spi_so), .spi_so_oe(spi_so_oe), .busy(busy),
    .soft_reset(soft_reset), .abort_cycle(abort_cycle),
    .reset_armed(reset_armed));
`default_nettype wire

// ### sfic_defs.vh
/*
 Constants for the serial flash identification and reset command block.
 Assumes inclusion by bare name from the design files.
*/
`ifndef SFIC_DEFS_VH
`define SFIC_DEFS_VH
// ----------------------------------------------------------------
// Opcodes
// ----------------------------------------------------------------
`define SFIC_OP_READ_ID     8'h9F
`define SFIC_OP_SERIAL_READ 8'h4B
`define SFIC_OP_RESET_ARM   8'h66
`define SFIC_OP_RESET_EXEC  8'h99
`define SFIC_OP_NO_OP       8'h00
// ----------------------------------------------------------------
// Lengths, then identity defaults (identity values arbitrary)
// ----------------------------------------------------------------
`define SFIC_BYTE_BITS      4'h8
`define SFIC_ID_BITS        8'h18
`define SFIC_SERIAL_BITS    8'h80
`define SFIC_DUMMY_BYTES    3'h4
`define SFIC_MFR_DEFAULT    8'hA5
`define SFIC_TYPE_DEFAULT   8'h5A
`define SFIC_DENS_DEFAULT   8'h3C
`endif

// ### sfic_host.sv
/* Serial host model: frames, opcode, dummies, read-back.
   Assumes a core clock at least four times the serial rate. */
`timescale 1ns/1ps
`default_nettype none
module sfic_host (
    input  wire logic core_clk,
    input  wire logic spi_so,
    output var  logic spi_cs_n,
    output var  logic spi_sclk,
    output var  logic spi_si
);
    // ------------------------------------------------------------
    // Frame task, mode 0, four core clocks high and five low per serial clock
    // ------------------------------------------------------------
    initial begin
        spi_cs_n = 1'b1;
        spi_sclk = 1'b0;
        spi_si = 1'b0;
    end
    task automatic frame(input logic [7:0] op, input int n,
                         output logic [127:0] rx);
        rx = '0;
        @(posedge core_clk) spi_cs_n <= 1'b0;
        for (int k = 0; k < n; k++) begin
            // Opcode first, then a toggling dummy pattern
            @(posedge core_clk) spi_si <= (k < 8) ? op[7 - k] : k[0];
            repeat (4) @(posedge core_clk);
            spi_sclk <= 1'b1;
            if (k >= 8) rx = {rx[126:0], spi_so};
            repeat (4) @(posedge core_clk);
            spi_sclk <= 1'b0;
        end
        repeat (4) @(posedge core_clk);
        spi_cs_n <= 1'b1;
        spi_si <= ~spi_si; // Released line never holds its last bit
        repeat (8) @(posedge core_clk);
    endtask
endmodule // sfic_host
`default_nettype wire

// ### sfic_rx_byte.v
/*
 Serial input byte assembler for the command block.
 Assumes spi_sclk and spi_cs_n are synchronous samples of the pins,
 taken at core_clk; the edge pulses come from the parent.
*/
`timescale 1ns/1ps
`default_nettype none
module sfic_rx_byte (
    input  wire       core_clk,
    input  wire       arst_n,
    input  wire       cs_active,
    input  wire       rise,
    input  wire       din,
    output reg  [7:0] rx_byte,
    output reg        rx_valid
);
    // ------------------------------------------------------------
    // Shift register, MSB first, sampled on rising edges
    // ------------------------------------------------------------
    reg [6:0] shift;
    reg [3:0] count;

    always @(posedge core_clk or negedge arst_n) begin
        if (!arst_n) begin
            shift    <= 7'h00;
            count    <= 4'h0;
            rx_byte  <= 8'h00;
            rx_valid <= 1'b0;
        end else begin
            rx_valid <= 1'b0;
            if (!cs_active) begin
                // Frame end discards partial bytes
                count <= 4'h0;
            end else if (rise) begin
                if (count == `SFIC_BYTE_BITS - 4'h1) begin
                    rx_byte  <= {shift, din};
                    rx_valid <= 1'b1;
                    count    <= 4'h0;
                end else begin
                    shift <= {shift[5:0], din};
                    count <= count + 4'h1;
                end
            end
        end
    end
endmodule // sfic_rx_byte
`default_nettype wire

// ### test_sfic_cmd.sv
/* Self-checking bench for sfic_cmd with a host model.
   Assumes sfic_defs.vh is on the include path. */
`timescale 1ns/1ps
`default_nettype none
`include "sfic_defs.vh"
module test_sfic_cmd;
    // Identity values arbitrary
    localparam logic [7:0] MFR = 8'hC3, MTYP = 8'h21, MDEN = 8'h17;
    localparam logic [127:0] SER = 128'hFEDCBA98765432E1_0F0F3C3C5A5A9669;
    logic core_clk = 1'b0, arst_n = 1'b0, busy = 1'b0;
    logic spi_cs_n, spi_sclk, spi_si, spi_so, spi_so_oe;
    logic soft_reset, abort_cycle, reset_armed;
    logic [31:0] seed = 32'd47;
    logic [127:0] rx;
    int fail_count = 0, n_checks = 0, n_rst = 0, n_abt = 0, n_oe = 0;
    int armed = 0, exp_rst = 0, exp_abt = 0;
    // Frames as {opcode, busy, clocks}; clocks FF means a random cut
    logic [23:0] plan [15] = '{24'h9F0020, 24'h9F00FF, 24'h660008,
        24'h000008, 24'h990008, 24'h660008, 24'h9F0020, 24'h990008,
        24'h660010, 24'h990008, 24'h9F0120, 24'h660108, 24'h990108,
        24'h4B00A8, 24'h4B00A8};
    sfic_cmd #(.MFR_ID(MFR), .MEM_TYPE(MTYP), .MEM_DENS(MDEN),
        .SERIAL_NO(SER)) i_sfic_cmd (.core_clk(core_clk), .arst_n(arst_n),
        .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_si(spi_si),
        .spi_so(spi_so), .spi_so_oe(spi_so_oe), .busy(busy),
        .soft_reset(soft_reset), .abort_cycle(abort_cycle),
        .reset_armed(reset_armed));
    sfic_host i_sfic_host (.core_clk(core_clk), .spi_so(spi_so),
        .spi_cs_n(spi_cs_n), .spi_sclk(spi_sclk), .spi_si(spi_si));
    initial forever #4 core_clk = ~core_clk;
    // Pulse counters compared after every frame, drive counter after busy frames
    always @(posedge core_clk) begin
        if (soft_reset) n_rst <= n_rst + 1;
        if (abort_cycle) n_abt <= n_abt + 1;
        if (spi_so_oe) n_oe <= n_oe + 1;
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        s = s ^ (s << 13);
        s = s ^ (s >> 17);
        return s ^ (s << 5);
    endfunction
    task automatic chk(input string what, input logic [127:0] seen, exp);
        n_checks++;
        if (seen !== exp) begin
            fail_count++;
            $display("[FAIL] %s expected %h seen %h", what, exp, seen);
        end
    endtask
    task automatic final_report;
        if (fail_count == 0 && n_checks > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // One frame, the model update, then every comparison
    task automatic run(input logic [7:0] op, input int n, input logic b);
        int oe0;
        busy <= b;
        oe0 = n_oe;
        i_sfic_host.frame(op, n, rx);
        if (op == `SFIC_OP_RESET_EXEC && armed != 0) begin
            exp_rst++;
            exp_abt += int'(b);
        end
        armed = int'(op == `SFIC_OP_RESET_ARM);
        if (b) chk("oe_busy", n_oe - oe0, 0);
        else if (op == `SFIC_OP_READ_ID)
            chk("id", rx, {MFR, MTYP, MDEN} >> (32 - n));
        else if (op == `SFIC_OP_SERIAL_READ) chk("serial", rx, SER);
        chk("armed", reset_armed, armed);
        chk("resets", n_rst, exp_rst);
        chk("aborts", n_abt, exp_abt);
        chk("oe_idle", spi_so_oe, 0);
    endtask
    initial begin
        repeat (20) @(posedge core_clk);
        arst_n <= 1'b1;
        @(posedge core_clk);
        foreach (plan[i]) begin
            seed = xs(seed);
            run(plan[i][23:16], (plan[i][7:0] == 8'hFF) ?
                int'(9 + seed % 23) : int'(plan[i][7:0]), plan[i][8]);
        end
        final_report;
    end
endmodule // test_sfic_cmd
`default_nettype wire
